// *** inc/cpu_clk_rst_pkg.sv ***
// package: constants for the processor clock, reset and bus command support block
`default_nettype none
package cpu_clk_rst_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   // power-up hold that stands in for the rc network; value is a plain default
   localparam int POR_TIME_NS = 16_000;
   localparam int POR_CYCLES_DEF = POR_TIME_NS / CLK_PERIOD_NS;
   // processor clock ticks the mode-switch reset is stretched over
   localparam int CPU_RST_TICKS = 16;
   localparam int CPU_RST_W = 5;
   // ---------------------------------------------------------------
   // pin input vector positions
   // ---------------------------------------------------------------
   localparam int PIN_W = 15;
   localparam int PIN_SPEED = 0;
   localparam int PIN_EXT = 1;
   localparam int PIN_XA = 2;
   localparam int PIN_XB = 3;
   localparam int PIN_STA = 4;
   localparam int PIN_STB = 5;
   localparam int PIN_MEM = 6;
   localparam int PIN_TERM_N = 7;
   localparam int PIN_DLY = 8;
   localparam int PIN_RDY_N = 9;
   localparam int PIN_HOLD = 10;
   localparam int PIN_WORD = 11;
   localparam int PIN_MODE_RST = 12;
   localparam int PIN_COPRO_RST = 13;
   localparam int PIN_BUSY_RST = 14;
   // idle levels of the synchronisers after reset
   localparam logic [PIN_W-1:0] PIN_RST = 15'h02B1;
   // ---------------------------------------------------------------
   // processor status encodings {status_b, status_a}
   // ---------------------------------------------------------------
   localparam logic [1:0] ST_IRQ_ACK = 2'h0;
   localparam logic [1:0] ST_READ = 2'h1;
   localparam logic [1:0] ST_WRITE = 2'h2;
   localparam logic [1:0] ST_IDLE = 2'h3;
   // ---------------------------------------------------------------
   // bus command states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_DELAY, BUS_CMD, BUS_DONE} bus_state_t;
endpackage
`default_nettype wire

// *** rtl/cpu_clock_reset_support.sv ***
// processor clock selection, power-up and software resets, ready and bus command generation
//
// Contract
// - with the speed switch open the speed-select line is driven high and the oscillator clocks the processor.
// - the processor clock runs at twice the execution rate, which the processor halves internally.
// - with the speed switch closed the processor clock comes from the crystal pair.
// - speed is switch-selectable between two rates and the higher rate is the reset default.
// - a power-up reset is generated and applied to both processor and coprocessor.
// - mode-switch, coprocessor and coprocessor-busy resets are NOR-combined with the power-up reset.
// - software triggers the mode-switch reset to leave protected operation and it reaches the processor.
// - the coprocessor software reset after an execution error is routed to the coprocessor.
// - the clock is squared up and reset and ready leave synchronised to that clock.
// - the active-low cycle-done output is low when the current bus cycle has completed.
// - bus commands derive from clock, cycle-done, both status lines, terminate and delay inputs.
// - memory and io strobes, irq ack, data enable, latch enable, memory select and hold grant are made.
// - commands serve byte devices on the board and byte or word devices on the channels.
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_reset_support
   import cpu_clk_rst_pkg::*;
#(
   parameter int POR_CYCLES = POR_CYCLES_DEF
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // clock sources and speed switch
   input wire logic i_speed_sw_open,
   input wire logic i_ext_freq_in,
   input wire logic i_crystal_in_a,
   input wire logic i_crystal_in_b,
   // software reset requests
   input wire logic i_mode_switch_reset,
   input wire logic i_copro_reset,
   input wire logic i_copro_busy_reset,
   // processor status and bus control inputs
   input wire logic i_cpu_status_a,
   input wire logic i_cpu_status_b,
   input wire logic i_mem_cycle,
   input wire logic i_cmd_term_n,
   input wire logic i_cmd_delay,
   input wire logic i_dev_ready_n,
   input wire logic i_hold_req,
   input wire logic i_word_dev,
   // clock and reset outputs
   output logic o_speed_sel,
   output logic o_cpu_clk,
   output logic o_exec_clk,
   output logic o_cpu_reset_n,
   output logic o_copro_reset_n,
   output logic o_cycle_done_n,
   // bus command outputs
   output logic o_mem_rd_n,
   output logic o_mem_wr_n,
   output logic o_io_rd_n,
   output logic o_io_wr_n,
   output logic o_irq_ack_n,
   output logic o_data_bus_enable,
   output logic o_addr_latch_en,
   output logic o_mem_io_sel,
   output logic o_word_xfer,
   output logic o_hold_grant
);

   localparam int POR_W = $clog2(POR_CYCLES + 1);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] sync_a;
   logic [PIN_W-1:0] sync_b;

   assign pin_raw[PIN_SPEED] = i_speed_sw_open;
   assign pin_raw[PIN_EXT] = i_ext_freq_in;
   assign pin_raw[PIN_XA] = i_crystal_in_a;
   assign pin_raw[PIN_XB] = i_crystal_in_b;
   assign pin_raw[PIN_STA] = i_cpu_status_a;
   assign pin_raw[PIN_STB] = i_cpu_status_b;
   assign pin_raw[PIN_MEM] = i_mem_cycle;
   assign pin_raw[PIN_TERM_N] = i_cmd_term_n;
   assign pin_raw[PIN_DLY] = i_cmd_delay;
   assign pin_raw[PIN_RDY_N] = i_dev_ready_n;
   assign pin_raw[PIN_HOLD] = i_hold_req;
   assign pin_raw[PIN_WORD] = i_word_dev;
   assign pin_raw[PIN_MODE_RST] = i_mode_switch_reset;
   assign pin_raw[PIN_COPRO_RST] = i_copro_reset;
   assign pin_raw[PIN_BUSY_RST] = i_copro_busy_reset;

   genvar g;
   generate
      for (g = 0; g < PIN_W; g = g + 1) begin : g_sync
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               sync_a[g] <= PIN_RST[g];
               sync_b[g] <= PIN_RST[g];
            end else begin
               sync_a[g] <= pin_raw[g];
               sync_b[g] <= sync_a[g];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // speed selection and clock source
   // ---------------------------------------------------------------
   logic speed_sel;
   logic src_lvl;
   logic src_q;
   logic tick;
   logic exec_phase;

   // higher rate until the switch has been sampled
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         speed_sel <= 1'b1;
      end else begin
         speed_sel <= sync_b[PIN_SPEED];
      end
   end

   // crystal pair read as a differential level
   always_comb begin
      if (speed_sel) begin
         src_lvl = sync_b[PIN_EXT];
      end else begin
         src_lvl = sync_b[PIN_XA] & ~sync_b[PIN_XB];
      end
   end

   // limitation: switching source mid-run may stretch one clock phase
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         src_q <= 1'b0;
      end else begin
         src_q <= src_lvl;
      end
   end

   assign tick = src_lvl & ~src_q;

   // processor halves its input, so this phase is the execution rate
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         exec_phase <= 1'b0;
      end else if (tick) begin
         exec_phase <= ~exec_phase;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_speed_sel <= 1'b1;
         o_cpu_clk <= 1'b0;
         o_exec_clk <= 1'b0;
      end else begin
         o_speed_sel <= speed_sel;
         o_cpu_clk <= src_lvl;
         o_exec_clk <= exec_phase;
      end
   end

   // ---------------------------------------------------------------
   // resets
   // ---------------------------------------------------------------
   logic [POR_W-1:0] por_cnt;
   logic por_active;
   logic mode_q;
   logic [CPU_RST_W-1:0] mode_cnt;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         por_cnt <= POR_W'(POR_CYCLES);
      end else if (por_cnt != '0) begin
         por_cnt <= por_cnt - 1'b1;
      end
   end

   assign por_active = (por_cnt != '0);

   // a short software pulse is stretched so the processor sees it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mode_q <= 1'b0;
         mode_cnt <= '0;
      end else begin
         mode_q <= sync_b[PIN_MODE_RST];
         if (sync_b[PIN_MODE_RST] && !mode_q) begin
            mode_cnt <= CPU_RST_W'(CPU_RST_TICKS);
         end else if (tick && mode_cnt != '0) begin
            mode_cnt <= mode_cnt - 1'b1;
         end
      end
   end

   // held asserted until the first clean clock edge after release
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_cpu_reset_n <= 1'b0;
         o_copro_reset_n <= 1'b0;
      end else if (tick) begin
         o_cpu_reset_n <= ~(por_active | (mode_cnt != '0));
         o_copro_reset_n <= ~(por_active | sync_b[PIN_COPRO_RST]
            | sync_b[PIN_BUSY_RST]);
      end
   end

   // ---------------------------------------------------------------
   // bus command generator
   // ---------------------------------------------------------------
   bus_state_t state;
   logic [1:0] stat;
   logic [1:0] cyc_stat;
   logic cyc_mem;
   logic cyc_word;
   logic cmd_on;

   assign stat = {sync_b[PIN_STB], sync_b[PIN_STA]};

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= BUS_IDLE;
         cyc_stat <= ST_IDLE;
         cyc_mem <= 1'b0;
         cyc_word <= 1'b0;
         cmd_on <= 1'b0;
         o_cycle_done_n <= 1'b1;
         o_addr_latch_en <= 1'b0;
         o_hold_grant <= 1'b0;
      end else if (tick) begin
         case (state)
            BUS_IDLE: begin
               o_cycle_done_n <= 1'b1;
               if (o_hold_grant) begin
                  o_hold_grant <= sync_b[PIN_HOLD];
               end else if (stat != ST_IDLE && o_cpu_reset_n) begin
                  cyc_stat <= stat;
                  cyc_mem <= sync_b[PIN_MEM];
                  cyc_word <= sync_b[PIN_WORD];
                  o_addr_latch_en <= 1'b1;
                  state <= BUS_ADDR;
               end else if (sync_b[PIN_HOLD]) begin
                  o_hold_grant <= 1'b1;
               end
            end
            BUS_ADDR: begin
               o_addr_latch_en <= 1'b0;
               if (sync_b[PIN_DLY]) begin
                  state <= BUS_DELAY;
               end else begin
                  cmd_on <= 1'b1;
                  state <= BUS_CMD;
               end
            end
            BUS_DELAY: begin
               if (!sync_b[PIN_DLY]) begin
                  cmd_on <= 1'b1;
                  state <= BUS_CMD;
               end
            end
            BUS_CMD: begin
               // early terminate drops the strobe, cycle still waits for ready
               if (!sync_b[PIN_TERM_N]) begin
                  cmd_on <= 1'b0;
               end
               if (!sync_b[PIN_RDY_N]) begin
                  cmd_on <= 1'b0;
                  o_cycle_done_n <= 1'b0;
                  state <= BUS_DONE;
               end
            end
            BUS_DONE: begin
               o_cycle_done_n <= 1'b1;
               state <= BUS_IDLE;
            end
            default: begin
               state <= BUS_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // command strobes
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_mem_rd_n <= 1'b1;
         o_mem_wr_n <= 1'b1;
         o_io_rd_n <= 1'b1;
         o_io_wr_n <= 1'b1;
         o_irq_ack_n <= 1'b1;
         o_data_bus_enable <= 1'b0;
         o_mem_io_sel <= 1'b0;
         o_word_xfer <= 1'b0;
      end else begin
         o_mem_rd_n <= ~(cmd_on && cyc_mem && cyc_stat == ST_READ);
         o_mem_wr_n <= ~(cmd_on && cyc_mem && cyc_stat == ST_WRITE);
         o_io_rd_n <= ~(cmd_on && !cyc_mem && cyc_stat == ST_READ);
         o_io_wr_n <= ~(cmd_on && !cyc_mem && cyc_stat == ST_WRITE);
         o_irq_ack_n <= ~(cmd_on && cyc_stat == ST_IRQ_ACK);
         o_data_bus_enable <= cmd_on;
         o_mem_io_sel <= cyc_mem;
         // board devices are byte wide, channel word devices request words
         o_word_xfer <= cyc_word;
      end
   end

endmodule // cpu_clock_reset_support
`default_nettype wire

// *** sim/cpu_clock_reset_support_props.sv ***
// checker: port-level properties of the clock, reset and bus command block
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_reset_support_props (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // watched inputs
   input wire logic i_speed_sw_open,
   input wire logic i_mode_switch_reset,
   input wire logic i_copro_reset,
   input wire logic i_copro_busy_reset,
   input wire logic i_cpu_status_a,
   input wire logic i_cpu_status_b,
   // watched outputs
   input wire logic o_speed_sel,
   input wire logic o_cpu_reset_n,
   input wire logic o_copro_reset_n,
   input wire logic o_cycle_done_n,
   input wire logic o_mem_rd_n,
   input wire logic o_mem_wr_n,
   input wire logic o_io_rd_n,
   input wire logic o_io_wr_n,
   input wire logic o_irq_ack_n,
   input wire logic o_data_bus_enable,
   input wire logic o_addr_latch_en,
   input wire logic o_hold_grant
);
   wire logic [4:0] stb_n = {o_irq_ack_n, o_io_wr_n, o_io_rd_n, o_mem_wr_n, o_mem_rd_n};
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_speed_open; i_speed_sw_open [*4] |=> o_speed_sel; endproperty
   a_speed_open: assert property (p_speed_open) else $error("speed select not high");
   property p_speed_closed; !i_speed_sw_open [*4] |=> !o_speed_sel; endproperty
   a_speed_closed: assert property (p_speed_closed) else $error("speed select not low");
   property p_por_hold; $fell(i_rst) |-> !o_cpu_reset_n && !o_copro_reset_n && (&stb_n); endproperty
   a_por_hold: assert property (p_por_hold) else $error("reset outputs wrong after reset");
   property p_mode_rst; $rose(i_mode_switch_reset) |-> ##[1:30] !o_cpu_reset_n; endproperty
   a_mode_rst: assert property (p_mode_rst) else $error("mode reset not applied");
   property p_copro_rst;
      (i_copro_reset || i_copro_busy_reset) [*8] |-> ##[0:16] !o_copro_reset_n;
   endproperty
   a_copro_rst: assert property (p_copro_rst) else $error("coprocessor reset not applied");
   property p_done_ends;
      $fell(o_cycle_done_n) |-> ##[0:1] ((&stb_n) && !o_data_bus_enable);
   endproperty
   a_done_ends: assert property (p_done_ends) else $error("command left on at cycle end");
   property p_done_len; $fell(o_cycle_done_n) |-> !o_cycle_done_n [*4] ##[1:12] o_cycle_done_n;
   endproperty
   a_done_len: assert property (p_done_len) else $error("cycle done width wrong");
   property p_ale_len; $rose(o_addr_latch_en) |-> o_addr_latch_en [*4] ##[1:12] !o_addr_latch_en;
   endproperty
   a_ale_len: assert property (p_ale_len) else $error("latch enable width wrong");
   property p_idle_quiet; (i_cpu_status_a && i_cpu_status_b) [*8] |-> !$rose(o_addr_latch_en);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("cycle began on idle status");
   property p_grant_quiet; o_hold_grant |-> &stb_n; endproperty
   a_grant_quiet: assert property (p_grant_quiet) else $error("command during hold grant");
   property p_one_cmd; !(&stb_n) |-> $onehot0(~stb_n) && o_data_bus_enable; endproperty
   a_one_cmd: assert property (p_one_cmd) else $error("strobes not exclusive");
endmodule // cpu_clock_reset_support_props
bind cpu_clock_reset_support cpu_clock_reset_support_props u_props (.*);
`default_nettype wire

// *** sim/bus_side_model.sv ***
// model of the processor side: clock sources and device ready answers
`timescale 1ns/100ps
`default_nettype none
module bus_side_model (
   // clock
   input wire logic i_clk,
   // bus side
   input wire logic i_busy,
   input wire logic [7:0] i_wait,
   // sources and answer
   output logic o_ext_freq_in,
   output logic o_crystal_in_a,
   output logic o_crystal_in_b,
   output logic o_dev_ready_n
);
   int oc = 0;
   int xc = 0;
   int wc = 0;
   initial begin
      o_ext_freq_in = 0;
      o_crystal_in_a = 0;
      o_crystal_in_b = 1;
      o_dev_ready_n = 1;
   end
   // scaled sources: oscillator period 8 clocks, crystal 12
   always @(posedge i_clk) begin
      oc <= (oc == 3) ? 0 : oc + 1;
      xc <= (xc == 5) ? 0 : xc + 1;
      if (oc == 3) o_ext_freq_in <= ~o_ext_freq_in;
      if (xc == 5) begin
         o_crystal_in_a <= ~o_crystal_in_a;
         o_crystal_in_b <= o_crystal_in_a;
      end
   end
   // ready held until the strobe is released
   always @(posedge i_clk) begin
      wc <= i_busy ? wc + 1 : 0;
      o_dev_ready_n <= !(i_busy && wc >= int'(i_wait));
   end
endmodule // bus_side_model
`default_nettype wire

// *** sim/cpu_clock_reset_support_test.sv ***
// self-checking bench for the processor clock, reset and bus command block
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_reset_support_test;
   import cpu_clk_rst_pkg::*;
   localparam int POR_SIM = 20;
   logic i_clk = 0, i_rst = 1, sw = 1, mrst = 0, crst = 0, brst = 0;
   logic sa = 1, sb = 1, mem = 0, dly = 0, hreq = 0, word = 0, term_n = 1;
   logic [7:0] wt = 8'h14;
   logic ext, xa, xb, rdy_n, spd, cclk, eclk, crn, prn, done_n;
   logic mrd, mwr, iord, iowr, iack, data_bus_enable, ale, msel, wx, hg;
   int bad_count = 0, total_checks = 0;
   wire logic [4:0] stb_n = {iack, iowr, iord, mwr, mrd};
   always #4 i_clk = ~i_clk;
   cpu_clock_reset_support #(.POR_CYCLES(POR_SIM)) u_cpu_clock_reset_support (
      .i_clk(i_clk), .i_rst(i_rst), .i_speed_sw_open(sw), .i_ext_freq_in(ext),
      .i_crystal_in_a(xa), .i_crystal_in_b(xb), .i_mode_switch_reset(mrst),
      .i_copro_reset(crst), .i_copro_busy_reset(brst), .i_cpu_status_a(sa),
      .i_cpu_status_b(sb), .i_mem_cycle(mem), .i_cmd_term_n(term_n), .i_cmd_delay(dly),
      .i_dev_ready_n(rdy_n), .i_hold_req(hreq), .i_word_dev(word), .o_speed_sel(spd),
      .o_cpu_clk(cclk), .o_exec_clk(eclk), .o_cpu_reset_n(crn), .o_copro_reset_n(prn),
      .o_cycle_done_n(done_n), .o_mem_rd_n(mrd), .o_mem_wr_n(mwr), .o_io_rd_n(iord),
      .o_io_wr_n(iowr), .o_irq_ack_n(iack), .o_data_bus_enable(data_bus_enable), .o_addr_latch_en(ale),
      .o_mem_io_sel(msel), .o_word_xfer(wx), .o_hold_grant(hg));
   // a cut command leaves the device busy, so ready still arrives to close the cycle
   bus_side_model u_bus_side_model (.i_clk(i_clk), .i_busy((~&stb_n) | ~term_n), .i_wait(wt),
      .o_ext_freq_in(ext), .o_crystal_in_a(xa), .o_crystal_in_b(xb), .o_dev_ready_n(rdy_n));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic close_out;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wait_for(ref logic s, input logic v, input int n, output logic ok);
      ok = 0;
      repeat (n) begin
         @(negedge i_clk);
         if (s === v) begin
            ok = 1;
            break;
         end
      end
   endtask
   task automatic count_edges(output int nc, output int ne);
      logic pc, pe;
      nc = 0;
      ne = 0;
      pc = cclk;
      pe = eclk;
      repeat (192) begin
         @(negedge i_clk);
         nc += int'(cclk && !pc);
         ne += int'(eclk && !pe);
         pc = cclk;
         pe = eclk;
      end
   endtask
   task automatic t_por;
      logic ok;
      repeat (8) @(negedge i_clk);
      check(crn, 0, "cpu reset in reset");
      check(prn, 0, "copro reset in reset");
      check(spd, 1, "default speed");
      i_rst = 0;
      repeat (10) @(negedge i_clk);
      check(crn, 0, "power-up hold");
      wait_for(crn, 1, 80, ok);
      check(ok, 1, "power-up release");
      check(prn, 1, "copro release");
      $display("t_por done");
   endtask
   task automatic t_speed;
      int nc, ne;
      repeat (8) @(negedge i_clk);
      check(spd, 1, "open switch");
      count_edges(nc, ne);
      check(nc inside {[23:25]}, 1, "oscillator rate");
      check(ne inside {[11:13]}, 1, "half rate");
      sw = 0;
      repeat (8) @(negedge i_clk);
      check(spd, 0, "closed switch");
      count_edges(nc, ne);
      check(nc inside {[15:17]}, 1, "crystal rate");
      check(ne inside {[7:9]}, 1, "crystal half rate");
      sw = 1;
      repeat (8) @(negedge i_clk);
      $display("t_speed done");
   endtask
   task automatic t_mode;
      logic ok;
      mrst = 1;
      wait_for(crn, 0, 40, ok);
      check(ok, 1, "mode reset applied");
      check(prn, 1, "copro untouched");
      repeat (60) @(negedge i_clk);
      check(crn, 0, "mode reset stretched");
      wait_for(crn, 1, 200, ok);
      check(ok, 1, "held request gives one stretch");
      mrst = 0;
      $display("t_mode done");
   endtask
   task automatic t_copro;
      logic ok;
      for (int i = 0; i < 2; i++) begin
         {brst, crst} = (i == 0) ? 2'b01 : 2'b10;
         wait_for(prn, 0, 40, ok);
         check(ok, 1, "copro reset applied");
         check(crn, 1, "cpu untouched");
         {brst, crst} = 2'b00;
         wait_for(prn, 1, 40, ok);
         check(ok, 1, "copro reset released");
      end
      $display("t_copro done");
   endtask
   task automatic t_bus;
      logic ok;
      logic [4:0] exp;
      for (int i = 0; i < 5; i++) begin
         exp = ~(5'h01 << ((i == 0) ? 4 : i - 1));
         mem = (i < 3);
         word = i[0];
         dly = (i == 1);
         wt = (i == 2) ? 8'h02 : 8'h28;
         {sb, sa} = (i == 0) ? ST_IRQ_ACK : ((i % 2) ? ST_READ : ST_WRITE);
         wait_for(ale, 1, 40, ok);
         check(ok, 1, "latch enable");
         if (i == 1) begin
            repeat (40) @(negedge i_clk);
            check(stb_n, 5'h1F, "delay holds command");
            dly = 0;
         end
         wait_for(data_bus_enable, 1, 40, ok);
         {sb, sa} = ST_IDLE;
         check(stb_n, exp, "strobe kind");
         if (i > 0) check(msel, mem, "memory select");
         check(wx, word, "word flag");
         wait_for(done_n, 0, 200, ok);
         check(ok, 1, "cycle done");
         wait_for(done_n, 1, 40, ok);
         check(ok, 1, "cycle done ends");
      end
      $display("t_bus done");
   endtask
   task automatic t_term;
      logic ok;
      mem = 1;
      wt = 8'h28;
      {sb, sa} = ST_READ;
      wait_for(data_bus_enable, 1, 40, ok);
      {sb, sa} = ST_IDLE;
      check(stb_n, 5'h1E, "read strobe before cut");
      term_n = 0;
      wait_for(data_bus_enable, 0, 20, ok);
      check(ok, 1, "terminate drops command");
      check(stb_n, 5'h1F, "terminate drops strobes");
      check(done_n, 1, "cut cycle still open");
      wait_for(done_n, 0, 200, ok);
      check(ok, 1, "ready ends cut cycle");
      wait_for(done_n, 1, 40, ok);
      term_n = 1;
      check(ok, 1, "cut cycle done ends");
      $display("t_term done");
   endtask
   task automatic t_hold;
      logic ok;
      hreq = 1;
      wait_for(hg, 1, 40, ok);
      check(ok, 1, "hold granted");
      hreq = 0;
      wait_for(hg, 0, 40, ok);
      check(ok, 1, "hold dropped");
      $display("t_hold done");
   endtask
   initial begin
      t_por();
      t_speed();
      t_mode();
      t_copro();
      t_bus();
      t_term();
      t_hold();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      bad_count++;
      close_out();
   end
endmodule // cpu_clock_reset_support_test
`default_nettype wire
